// [rtl/fcd_pkg.sv]
// shared constants and types of the flash command decoder
package fcd_pkg;
    localparam int ADDR_W  = 23;
    localparam int DATA_W  = 16;
    localparam int BLK_LSB = 17;
    localparam int BLK_W   = 6;
    localparam int NBLK    = 64;
    localparam int CNT_W   = 6;
    localparam logic [CNT_W-1:0] BUF_MAX = 6'h20;

    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_CLEAR      = 8'h50;
    localparam logic [7:0] CMD_ID         = 8'h90;
    localparam logic [7:0] CMD_CFI        = 8'h98;
    localparam logic [7:0] CMD_WORD       = 8'h40;
    localparam logic [7:0] CMD_WORD_ALT   = 8'h10;
    localparam logic [7:0] CMD_BUF        = 8'he8;
    localparam logic [7:0] CMD_FFP        = 8'h80;
    localparam logic [7:0] CMD_ERASE      = 8'h20;
    localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
    localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
    localparam logic [7:0] CMD_SETUP60    = 8'h60;
    localparam logic [7:0] CMD_LOCK       = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN   = 8'h2f;
    localparam logic [7:0] CMD_SET_CFG    = 8'h03;
    localparam logic [7:0] CMD_PROT       = 8'hc0;

    localparam int SR_PROG_ERR  = 4;
    localparam int SR_ERASE_ERR = 5;
    localparam logic [16:0] ID_LOCK_OFS = 17'h0_0002;
    localparam logic [8:0]  ID_RCR_OFS  = 9'h005;
    localparam logic [DATA_W-1:0] RCR_RST = 16'hbfcf;
    localparam logic [NBLK-1:0] LOCK_RST = {NBLK{1'b1}};

    typedef enum logic [2:0] {
        FCD_RM_ARRAY, FCD_RM_STATUS, FCD_RM_ID, FCD_RM_CFI
    } fcd_rmode_t;

    typedef enum logic [3:0] {
        FCD_CS_IDLE, FCD_CS_WORD, FCD_CS_BUF_CNT, FCD_CS_BUF_DATA, FCD_CS_FFP_SET,
        FCD_CS_FFP_STREAM, FCD_CS_ERASE, FCD_CS_SETUP60, FCD_CS_PROT
    } fcd_cstate_t;

    // work handed to the internal_write_sequencer
    typedef enum logic [3:0] {
        FCD_OP_NONE, FCD_OP_WORD_PROG, FCD_OP_BUF_DATA, FCD_OP_BUF_PROG, FCD_OP_FFP_START,
        FCD_OP_FFP_DATA, FCD_OP_ERASE, FCD_OP_PROT_PROG, FCD_OP_SUSPEND, FCD_OP_RESUME
    } fcd_op_t;

    typedef enum logic [4:0] {
        FCD_H_RAW_WRITE, FCD_H_READ, FCD_H_READ_ARRAY, FCD_H_STATUS, FCD_H_CLEAR,
        FCD_H_ID, FCD_H_CFI, FCD_H_SUSPEND, FCD_H_RESUME, FCD_H_WORD, FCD_H_BUF,
        FCD_H_FFP, FCD_H_ERASE, FCD_H_LOCK, FCD_H_UNLOCK, FCD_H_LOCKDOWN, FCD_H_PROT,
        FCD_H_CONFIG
    } fcd_hop_t;
endpackage

// [rtl/fcd_bus_if.sv]
// parallel flash bus between host controller and device front end
`timescale 1ns/10ps
`default_nettype none
interface fcd_bus_if;
    import fcd_pkg::*;
    logic              wr;
    logic              rd;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;

    modport dev (
        input  wr,
        input  rd,
        input  rst_n,
        input  addr,
        input  wdata,
        output rdata,
        output rvalid
    );
    modport host (
        output wr,
        output rd,
        output rst_n,
        output addr,
        output wdata,
        input  rdata,
        input  rvalid
    );
endinterface
`default_nettype wire

// [rtl/fcd_device.sv]
// device end: command_front_end of the flash, decodes bus writes
`timescale 1ns/10ps
`default_nettype none
module fcd_device
    import fcd_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    fcd_bus_if.dev                     bus,
    input  wire logic                  seq_busy_i,
    input  wire logic                  ffp_done_i,
    input  wire logic [7:0]            seq_status_i,
    input  wire logic [DATA_W-1:0]     array_data_i,
    input  wire logic [DATA_W-1:0]     id_data_i,
    input  wire logic [DATA_W-1:0]     cfi_data_i,
    output logic [ADDR_W-1:0]          rd_addr_o,
    output logic                       op_valid_o,
    output fcd_pkg::fcd_op_t           op_kind_o,
    output logic [ADDR_W-1:0]          op_addr_o,
    output logic [DATA_W-1:0]          op_data_o,
    output logic                       seq_abort_o,
    output logic [DATA_W-1:0]          rcr_o,
    output logic [NBLK-1:0]            locked_o,
    output logic [NBLK-1:0]            lockdown_o
);
    import fcd_pkg::*;

    typedef struct packed {
        fcd_cstate_t         st;
        fcd_rmode_t          mode;
        logic                perr;
        logic                eerr;
        logic [CNT_W-1:0]    cnt;
        logic [DATA_W-1:0]   rcr;
        logic [NBLK-1:0]     lk;
        logic [NBLK-1:0]     ld;
        logic                rd_pend;
        logic [ADDR_W-1:0]   rd_addr;
        logic [DATA_W-1:0]   rdata;
        logic                rvalid;
        logic                op_valid;
        fcd_op_t             op_kind;
        logic [ADDR_W-1:0]   op_addr;
        logic [DATA_W-1:0]   op_data;
        logic                abort;
    } fcd_dev_t;

    fcd_dev_t s_r;
    fcd_dev_t s_nxt;

    function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
        return a[BLK_LSB +: BLK_W];
    endfunction

    logic [7:0]        cmd;
    logic [BLK_W-1:0]  wblk;
    logic [BLK_W-1:0]  rblk;
    logic              link_rst;

    assign cmd      = bus.wdata[7:0];
    assign wblk     = blk_of(bus.addr);
    assign rblk     = blk_of(s_r.rd_addr);
    // the reset pin aborts any running operation
    assign link_rst = ~bus.rst_n;

    always_comb begin
        s_nxt          = s_r;
        s_nxt.rvalid   = 1'b0;
        s_nxt.op_valid = 1'b0;
        s_nxt.op_kind  = FCD_OP_NONE;
        s_nxt.rd_pend  = 1'b0;
        s_nxt.abort    = 1'b0;

        // user data answers rd_addr_o one cycle after capture
        if (s_r.rd_pend) begin
            s_nxt.rvalid = 1'b1;
            unique case (s_r.mode)
                FCD_RM_ARRAY: s_nxt.rdata = array_data_i;
                FCD_RM_STATUS: begin
                    s_nxt.rdata = {8'h00, seq_status_i[7:6], s_r.eerr, s_r.perr, seq_status_i[3:0]};
                end
                FCD_RM_ID: begin
                    if (s_r.rd_addr[16:0] == ID_LOCK_OFS) begin
                        s_nxt.rdata = {14'h0000, s_r.ld[rblk], s_r.lk[rblk]};
                    end else if (s_r.rd_addr[8:0] == ID_RCR_OFS) begin
                        s_nxt.rdata = s_r.rcr;
                    end else begin
                        s_nxt.rdata = id_data_i;
                    end
                end
                FCD_RM_CFI: s_nxt.rdata = cfi_data_i;
                default: s_nxt.rdata = array_data_i;
            endcase
        end
        if (bus.rd) begin
            s_nxt.rd_pend = 1'b1;
            s_nxt.rd_addr = bus.addr;
        end

        // fast factory streaming ends on the sequencer's word, not a command
        if (s_r.st == FCD_CS_FFP_STREAM && ffp_done_i) begin
            s_nxt.st = FCD_CS_IDLE;
        end

        if (bus.wr) begin
            s_nxt.op_addr = bus.addr;
            s_nxt.op_data = bus.wdata;
            // second cycle evaluated: pending setup drops unless a buffer sequence or the stream keeps it
            s_nxt.st = FCD_CS_IDLE;
            unique case (s_r.st)
                FCD_CS_IDLE: begin
                    if (seq_busy_i && cmd != CMD_STATUS && cmd != CMD_SUSPEND) begin
                        s_nxt.st = FCD_CS_IDLE;
                    end else begin
                        case (cmd)
                            CMD_READ_ARRAY: s_nxt.mode = FCD_RM_ARRAY;
                            CMD_STATUS:     s_nxt.mode = FCD_RM_STATUS;
                            CMD_ID:         s_nxt.mode = FCD_RM_ID;
                            CMD_CFI:        s_nxt.mode = FCD_RM_CFI;
                            CMD_CLEAR: begin
                                s_nxt.perr = 1'b0;
                                s_nxt.eerr = 1'b0;
                            end
                            CMD_SUSPEND: begin
                                s_nxt.op_valid = 1'b1;
                                s_nxt.op_kind  = FCD_OP_SUSPEND;
                            end
                            CMD_CONFIRM: begin
                                s_nxt.op_valid = 1'b1;
                                s_nxt.op_kind  = FCD_OP_RESUME;
                            end
                            CMD_WORD, CMD_WORD_ALT: s_nxt.st = FCD_CS_WORD;
                            CMD_BUF:     s_nxt.st = FCD_CS_BUF_CNT;
                            CMD_FFP:     s_nxt.st = FCD_CS_FFP_SET;
                            CMD_ERASE:   s_nxt.st = FCD_CS_ERASE;
                            CMD_SETUP60: s_nxt.st = FCD_CS_SETUP60;
                            CMD_PROT:    s_nxt.st = FCD_CS_PROT;
                            default:     s_nxt.st = FCD_CS_IDLE;
                        endcase
                    end
                end
                FCD_CS_WORD: begin
                    s_nxt.op_valid = 1'b1;
                    s_nxt.op_kind  = FCD_OP_WORD_PROG;
                    s_nxt.mode     = FCD_RM_STATUS;
                end
                FCD_CS_BUF_CNT: begin
                    if (bus.wdata > DATA_W'(BUF_MAX - 6'h01)) begin
                        s_nxt.perr = 1'b1;
                        s_nxt.eerr = 1'b1;
                        s_nxt.mode = FCD_RM_STATUS;
                    end else begin
                        s_nxt.cnt = bus.wdata[CNT_W-1:0] + 6'h01;
                        s_nxt.st  = FCD_CS_BUF_DATA;
                    end
                end
                FCD_CS_BUF_DATA: begin
                    if (s_r.cnt != '0) begin
                        s_nxt.cnt      = s_r.cnt - 6'h01;
                        s_nxt.st       = FCD_CS_BUF_DATA;
                        s_nxt.op_valid = 1'b1;
                        s_nxt.op_kind  = FCD_OP_BUF_DATA;
                    end else if (cmd == CMD_CONFIRM) begin
                        s_nxt.op_valid = 1'b1;
                        s_nxt.op_kind  = FCD_OP_BUF_PROG;
                        s_nxt.mode     = FCD_RM_STATUS;
                    end else begin
                        s_nxt.perr = 1'b1;
                        s_nxt.eerr = 1'b1;
                        s_nxt.mode = FCD_RM_STATUS;
                    end
                end
                FCD_CS_FFP_SET: begin
                    if (cmd == CMD_CONFIRM) begin
                        s_nxt.op_valid = 1'b1;
                        s_nxt.op_kind  = FCD_OP_FFP_START;
                        s_nxt.st       = FCD_CS_FFP_STREAM;
                    end else begin
                        s_nxt.perr = 1'b1;
                        s_nxt.eerr = 1'b1;
                        s_nxt.mode = FCD_RM_STATUS;
                    end
                end
                FCD_CS_FFP_STREAM: begin
                    // every write is stream data unless ffp_done_i comes in the same cycle; commands are ignored here
                    s_nxt.op_valid = ~ffp_done_i;
                    s_nxt.op_kind  = ffp_done_i ? FCD_OP_NONE : FCD_OP_FFP_DATA;
                    s_nxt.st       = ffp_done_i ? FCD_CS_IDLE : FCD_CS_FFP_STREAM;
                end
                FCD_CS_ERASE: begin
                    if (cmd == CMD_CONFIRM) begin
                        s_nxt.op_valid = 1'b1;
                        s_nxt.op_kind  = FCD_OP_ERASE;
                    end else begin
                        s_nxt.perr = 1'b1;
                        s_nxt.eerr = 1'b1;
                    end
                    s_nxt.mode = FCD_RM_STATUS;
                end
                FCD_CS_SETUP60: begin
                    case (cmd)
                        CMD_LOCK: s_nxt.lk[wblk] = 1'b1;
                        CMD_CONFIRM: begin
                            if (!s_r.ld[wblk]) begin
                                s_nxt.lk[wblk] = 1'b0;
                            end
                        end
                        CMD_LOCKDOWN: begin
                            s_nxt.lk[wblk] = 1'b1;
                            s_nxt.ld[wblk] = 1'b1;
                        end
                        CMD_SET_CFG: begin
                            s_nxt.rcr  = bus.addr[DATA_W-1:0];
                            s_nxt.mode = FCD_RM_ARRAY;
                        end
                        default: begin
                            s_nxt.perr = 1'b1;
                            s_nxt.eerr = 1'b1;
                            s_nxt.mode = FCD_RM_STATUS;
                        end
                    endcase
                end
                FCD_CS_PROT: begin
                    s_nxt.op_valid = 1'b1;
                    s_nxt.op_kind  = FCD_OP_PROT_PROG;
                    s_nxt.mode     = FCD_RM_STATUS;
                end
                default: s_nxt.st = FCD_CS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || link_rst) begin
            s_r          <= '0;
            s_r.st       <= FCD_CS_IDLE;
            s_r.mode     <= FCD_RM_ARRAY;
            s_r.op_kind  <= FCD_OP_NONE;
            s_r.rcr      <= RCR_RST;
            s_r.lk       <= LOCK_RST;
            s_r.abort    <= link_rst;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.rdata  = s_r.rdata;
    assign bus.rvalid = s_r.rvalid;
    assign rd_addr_o  = s_r.rd_addr;
    assign op_valid_o = s_r.op_valid;
    assign op_kind_o  = s_r.op_kind;
    assign op_addr_o  = s_r.op_addr;
    assign op_data_o  = s_r.op_data;
    assign seq_abort_o = s_r.abort;
    assign rcr_o      = s_r.rcr;
    assign locked_o   = s_r.lk;
    assign lockdown_o = s_r.ld;
endmodule
`default_nettype wire

// [rtl/fcd_host.sv]
// host end: turns user requests into flash bus command cycles
`timescale 1ns/10ps
`default_nettype none
module fcd_host
    import fcd_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    fcd_bus_if.host                    bus,
    input  wire logic                  flash_reset_i,
    input  wire logic                  req_i,
    input  wire fcd_pkg::fcd_hop_t     req_op_i,
    input  wire logic [ADDR_W-1:0]     req_addr_i,
    input  wire logic [DATA_W-1:0]     req_data_i,
    output logic                       req_ready_o,
    output logic [DATA_W-1:0]          rsp_data_o,
    output logic                       rsp_valid_o
);
    import fcd_pkg::*;

    typedef enum logic [1:0] {
        FCD_HS_IDLE, FCD_HS_GAP, FCD_HS_SECOND, FCD_HS_WAIT_RD
    } fcd_hstate_t;

    typedef struct packed {
        fcd_hstate_t         st;
        logic                wr;
        logic                rd;
        logic                rst_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W-1:0]   data2;
        logic                rdy;
        logic [DATA_W-1:0]   rsp;
        logic                rsp_v;
    } fcd_host_t;

    fcd_host_t h_r;
    fcd_host_t h_nxt;

    function automatic logic [7:0] first_code(input fcd_hop_t op);
        unique case (op)
            FCD_H_READ_ARRAY: return CMD_READ_ARRAY;
            FCD_H_STATUS:     return CMD_STATUS;
            FCD_H_CLEAR:      return CMD_CLEAR;
            FCD_H_ID:         return CMD_ID;
            FCD_H_CFI:        return CMD_CFI;
            FCD_H_SUSPEND:    return CMD_SUSPEND;
            FCD_H_RESUME:     return CMD_CONFIRM;
            FCD_H_WORD:       return CMD_WORD;
            FCD_H_BUF:        return CMD_BUF;
            FCD_H_FFP:        return CMD_FFP;
            FCD_H_ERASE:      return CMD_ERASE;
            FCD_H_PROT:       return CMD_PROT;
            FCD_H_LOCK, FCD_H_UNLOCK, FCD_H_LOCKDOWN, FCD_H_CONFIG: return CMD_SETUP60;
            default:          return 8'h00;
        endcase
    endfunction

    function automatic logic two_cycle(input fcd_hop_t op);
        return op inside {FCD_H_WORD, FCD_H_BUF, FCD_H_FFP, FCD_H_ERASE, FCD_H_PROT,
                          FCD_H_LOCK, FCD_H_UNLOCK, FCD_H_LOCKDOWN, FCD_H_CONFIG};
    endfunction

    always_comb begin
        h_nxt       = h_r;
        h_nxt.wr    = 1'b0;
        h_nxt.rd    = 1'b0;
        h_nxt.rsp_v = 1'b0;
        h_nxt.rst_n = ~flash_reset_i;
        unique case (h_r.st)
            FCD_HS_IDLE: begin
                if (req_i && h_r.rdy) begin
                    // target address stands from the first cycle on
                    h_nxt.addr  = req_addr_i;
                    h_nxt.data2 = req_data_i;
                    if (req_op_i == FCD_H_READ) begin
                        h_nxt.rd = 1'b1;
                        h_nxt.st = FCD_HS_WAIT_RD;
                    end else begin
                        h_nxt.wr    = 1'b1;
                        h_nxt.wdata = (req_op_i == FCD_H_RAW_WRITE) ? req_data_i
                                                                     : {8'h00, first_code(req_op_i)};
                        h_nxt.st    = two_cycle(req_op_i) ? FCD_HS_GAP : FCD_HS_IDLE;
                    end
                    unique case (req_op_i)
                        FCD_H_FFP, FCD_H_ERASE, FCD_H_UNLOCK: h_nxt.data2 = {8'h00, CMD_CONFIRM};
                        FCD_H_LOCK:     h_nxt.data2 = {8'h00, CMD_LOCK};
                        FCD_H_LOCKDOWN: h_nxt.data2 = {8'h00, CMD_LOCKDOWN};
                        FCD_H_CONFIG: begin
                            h_nxt.addr  = {{(ADDR_W-DATA_W){1'b0}}, req_data_i};
                            h_nxt.data2 = {8'h00, CMD_SET_CFG};
                        end
                        default: h_nxt.data2 = req_data_i;
                    endcase
                end
            end
            FCD_HS_GAP:    h_nxt.st = FCD_HS_SECOND;
            FCD_HS_SECOND: begin
                h_nxt.wr    = 1'b1;
                h_nxt.wdata = h_r.data2;
                h_nxt.st    = FCD_HS_IDLE;
            end
            FCD_HS_WAIT_RD: begin
                if (bus.rvalid) begin
                    h_nxt.rsp   = bus.rdata;
                    h_nxt.rsp_v = 1'b1;
                    h_nxt.st    = FCD_HS_IDLE;
                end
            end
        endcase
        h_nxt.rdy = (h_nxt.st == FCD_HS_IDLE) && !(h_r.st == FCD_HS_IDLE && req_i && h_r.rdy);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_r       <= '0;
            h_r.st    <= FCD_HS_IDLE;
            h_r.rst_n <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign bus.wr      = h_r.wr;
    assign bus.rd      = h_r.rd;
    assign bus.rst_n   = h_r.rst_n;
    assign bus.addr    = h_r.addr;
    assign bus.wdata   = h_r.wdata;
    assign req_ready_o = h_r.rdy;
    assign rsp_data_o  = h_r.rsp;
    assign rsp_valid_o = h_r.rsp_v;
endmodule
`default_nettype wire

// [sim/fcd_monitor.sv]
// bus protocol assertions between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module fcd_monitor
    import fcd_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              rvalid
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence erase_s;
        // a buffer count whose low byte reads 0x20 is not an erase setup
        wr && wdata[7:0] == CMD_ERASE && !($past(wr, 2) && $past(wdata[7:0], 2) == CMD_BUF);
    endsequence
    sequence confirm_s;
        wr && wdata[7:0] == CMD_CONFIRM && $stable(addr);
    endsequence
    rd_latency_a: assert property (rd && rst_n |-> ##2 rvalid) else $error("read answer late");
    rvalid_cause_a: assert property (rvalid |-> $past(rd, 2)) else $error("answer without read");
    wr_pulse_a: assert property (wr |=> !wr) else $error("write strobe too long");
    rd_pulse_a: assert property (rd |=> !rd) else $error("read strobe too long");
    bus_excl_a: assert property (!(wr && rd)) else $error("read and write together");
    erase_pair_a: assert property (erase_s |=> !wr ##1 confirm_s) else $error("erase pair broken");
    reset_quiet_a: assert property (!rst_n |=> !rvalid) else $error("answer during reset");
    cfg_addr_a: assert property (wr && wdata[7:0] == CMD_SET_CFG |-> $past(wr, 2)
        && $past(wdata[7:0], 2) == CMD_SETUP60 && addr == $past(addr, 2)) else $error("config address moved");
endmodule
`default_nettype wire

// [sim/flash_command_decoder_tb.sv]
// self-checking bench: host and device ends joined over the flash bus
`timescale 1ns/10ps
`default_nettype none
module flash_command_decoder_tb;
    import fcd_pkg::*;
    localparam logic [22:0] BA = 23'h06_0000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        busy = 1'b0;
    logic        ffp_done = 1'b0;
    logic        flash_reset = 1'b0;
    logic        req = 1'b0;
    fcd_hop_t    op = FCD_H_READ;
    logic [22:0] raddr = 23'h00_0000;
    logic [15:0] rdat = 16'h0000;
    logic        ready;
    logic [15:0] rsp, op_d, rcr, last_d;
    logic [22:0] rd_addr, last_a;
    logic        op_v, abort, rsp_v;
    int          rsp_count = 0;
    fcd_op_t     op_k;
    fcd_op_t     last_op = FCD_OP_NONE;
    logic [63:0] lk, ld;
    int          compares = 0;
    int          miscompares = 0;
    fcd_bus_if bus_if();
    always #2.5 clk_i = ~clk_i;
    fcd_device i_fcd_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.dev), .seq_busy_i(busy),
        .ffp_done_i(ffp_done), .seq_status_i(8'h80), .array_data_i(rd_addr[15:0] ^ 16'ha5a5),
        .id_data_i(16'h00aa), .cfi_data_i(16'h0c0f), .rd_addr_o(rd_addr), .op_valid_o(op_v),
        .op_kind_o(op_k), .op_addr_o(last_a), .op_data_o(op_d), .seq_abort_o(abort), .rcr_o(rcr),
        .locked_o(lk), .lockdown_o(ld));
    fcd_host i_fcd_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.host), .flash_reset_i(flash_reset),
        .req_i(req), .req_op_i(op), .req_addr_i(raddr), .req_data_i(rdat), .req_ready_o(ready),
        .rsp_data_o(rsp), .rsp_valid_o(rsp_v));
    fcd_monitor i_fcd_monitor (.clk_i(clk_i), .rst_i(rst_i), .wr(bus_if.wr), .rd(bus_if.rd),
        .rst_n(bus_if.rst_n), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .rvalid(bus_if.rvalid));
    // op pulses stand one cycle, so keep the last one for later compares
    always @(posedge clk_i) begin
        if (op_v === 1'b1) begin
            last_op <= op_k;
            last_d <= op_d;
        end
        if (rsp_v === 1'b1) begin
            rsp_count <= rsp_count + 1;
        end
    end
    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_op(input fcd_op_t exp);
        chk({12'h000, last_op}, {12'h000, exp});
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (ready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
    endtask
    // one user request, returns once the host is idle and the device has settled
    task automatic send(input fcd_hop_t o, input logic [22:0] a, input logic [15:0] d);
        wait_rdy();
        req <= 1'b1;
        op <= o;
        raddr <= a;
        rdat <= d;
        @(posedge clk_i);
        req <= 1'b0;
        @(posedge clk_i);
        wait_rdy();
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rd(input logic [22:0] a, input logic [15:0] exp);
        send(FCD_H_READ, a, 16'h0000);
        chk(rsp, exp);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        send(FCD_H_UNLOCK, BA, 16'h0000);
        chk({14'h0000, ld[3], lk[3]}, 16'h0000);
        send(FCD_H_LOCK, BA, 16'h0000);
        chk({14'h0000, ld[3], lk[3]}, 16'h0001);
        send(FCD_H_LOCKDOWN, BA, 16'h0000);
        send(FCD_H_UNLOCK, BA, 16'h0000);
        chk({14'h0000, ld[3], lk[3]}, 16'h0003);
        send(FCD_H_CONFIG, 23'h00_0000, 16'h1234);
        chk(rcr, 16'h1234);
        rd(23'h00_0040, 16'ha5e5);
        send(FCD_H_RAW_WRITE, 23'h00_0000, 16'h0060);
        send(FCD_H_RAW_WRITE, 23'h00_0000, 16'h00ff);
        rd(23'h00_0000, 16'h00b0);
        send(FCD_H_CLEAR, 23'h7f_0000, 16'h0000);
        send(FCD_H_RAW_WRITE, 23'h00_0000, 16'h0060);
        send(FCD_H_RAW_WRITE, 23'h00_0000, 16'h0055);
        rd(23'h00_0000, 16'h00b0);
        send(FCD_H_CLEAR, 23'h7f_0000, 16'h0000);
        send(FCD_H_STATUS, 23'h12_3456, 16'h0000);
        rd(23'h7f_ffff, 16'h0080);
        send(FCD_H_ID, 23'h00_0000, 16'h0000);
        rd(BA | 23'h00_0002, 16'h0003);
        rd(23'h00_0005, 16'h1234);
        rd(23'h00_0010, 16'h00aa);
        send(FCD_H_CFI, 23'h00_0000, 16'h0000);
        rd(23'h00_0010, 16'h0c0f);
        send(FCD_H_READ_ARRAY, 23'h7f_0000, 16'h0000);
        rd(23'h00_0040, 16'ha5e5);
        send(FCD_H_WORD, 23'h00_0100, 16'hbeef);
        chk_op(FCD_OP_WORD_PROG);
        chk(last_d, 16'hbeef);
        send(FCD_H_ERASE, BA, 16'h0000);
        chk_op(FCD_OP_ERASE);
        chk(last_a[15:0], BA[15:0]);
        chk({9'h000, last_a[22:16]}, {9'h000, BA[22:16]});
        busy <= 1'b1;
        send(FCD_H_WORD, 23'h00_0100, 16'h1111);
        chk_op(FCD_OP_ERASE);
        send(FCD_H_SUSPEND, 23'h7f_fff0, 16'h0000);
        chk_op(FCD_OP_SUSPEND);
        busy <= 1'b0;
        send(FCD_H_RESUME, 23'h00_0000, 16'h0000);
        chk_op(FCD_OP_RESUME);
        send(FCD_H_RAW_WRITE, 23'h00_0100, 16'h0010);
        send(FCD_H_RAW_WRITE, 23'h00_0100, 16'h4321);
        chk_op(FCD_OP_WORD_PROG);
        chk(last_d, 16'h4321);
        send(FCD_H_BUF, 23'h00_0200, 16'h0001);
        send(FCD_H_RAW_WRITE, 23'h00_0200, 16'h1111);
        send(FCD_H_RAW_WRITE, 23'h00_0200, 16'h2222);
        chk_op(FCD_OP_BUF_DATA);
        send(FCD_H_RAW_WRITE, 23'h00_0200, 16'h00d0);
        chk_op(FCD_OP_BUF_PROG);
        send(FCD_H_BUF, 23'h00_0200, 16'h0020);
        rd(23'h00_0000, 16'h00b0);
        send(FCD_H_CLEAR, 23'h00_0000, 16'h0000);
        send(FCD_H_FFP, 23'h00_0300, 16'h0000);
        chk_op(FCD_OP_FFP_START);
        send(FCD_H_RAW_WRITE, 23'h00_0300, 16'h5555);
        chk_op(FCD_OP_FFP_DATA);
        ffp_done <= 1'b1;
        @(posedge clk_i);
        ffp_done <= 1'b0;
        send(FCD_H_PROT, 23'h00_0080, 16'h0002);
        chk_op(FCD_OP_PROT_PROG);
        flash_reset <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({15'h0000, abort}, 16'h0001);
        chk({14'h0000, ld[3], lk[3]}, 16'h0001);
        flash_reset <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(16'(rsp_count), 16'h000a);
        end_of_test();
    end
endmodule
`default_nettype wire
